/* File: rtl/rls_regs.sv */
// register bank for regulator a hibernate and regulator b mode/sequencing
// assumes a classic wishbone master, a power state machine that pulses
// slot ticks and state entries, and mask-programmed defaults on ports
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module rls_regs
   import rls_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [RLS_ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // mask-programmed defaults and state machine reload
   input wire logic sm_reload_i,
   input wire logic [15:0] mask_a_low_power_i,
   input wire logic [15:0] mask_b_control_i,
   input wire logic [15:0] mask_b_timeouts_i,
   // hibernate sources and regulator a normal settings
   input wire logic low_power_line_one_i,
   input wire logic low_power_line_two_i,
   input wire logic low_power_line_three_i,
   input wire logic reg_a_normal_en_i,
   input wire logic [4:0] reg_a_normal_code_i,
   // power sequencer events
   input wire logic startup_tick_i,
   input wire logic shutdown_tick_i,
   input wire logic [3:0] slot_num_i,
   input wire logic active_entry_i,
   input wire logic off_entry_i,
   input wire logic reg_b_fault_i,
   input wire logic [2:0] others_en_i,
   // regulator controls
   output logic reg_a_en_o,
   output logic [11:0] reg_a_out_mv_o,
   output logic reg_a_in_sleep_o,
   output logic reg_b_en_o,
   output logic reg_b_switch_o,
   output logic [11:0] reg_b_out_mv_o,
   output logic reg_b_discharge_o,
   output logic all_discharge_o,
   output logic system_shutdown_o,
   output logic irq_o
);
   logic [15:0] ldo_a_low_power;
   logic [15:0] ldo_b_control;
   logic [15:0] ldo_b_timeouts;
   logic [RLS_IRQ_W-1:0] irq_status;
   logic [RLS_IRQ_W-1:0] irq_mask;
   logic hib_bit;
   rls_b_state_e b_state;
   rls_b_state_e next_b_state;

   // field views
   wire [1:0] reg_a_sleep_behaviour = ldo_a_low_power[RLS_A_BEHAV_LSB +: 2];
   wire [1:0] reg_a_sleep_source = ldo_a_low_power[RLS_A_SOURCE_LSB +: 2];
   wire [4:0] reg_a_sleep_voltage = ldo_a_low_power[RLS_A_VOLT_LSB +: 5];
   wire reg_b_switch_mode = ldo_b_control[RLS_B_SWITCH_BIT];
   wire reg_b_float_output = ldo_b_control[RLS_B_FLOAT_BIT];
   wire [4:0] reg_b_voltage_select = ldo_b_control[RLS_B_VSEL_LSB +: 5];
   wire [1:0] reg_b_fault_action = ldo_b_timeouts[RLS_B_ACTION_LSB +: 2];
   wire [3:0] reg_b_startup_slot = ldo_b_timeouts[RLS_B_START_LSB +: 4];
   wire [3:0] reg_b_shutdown_slot = ldo_b_timeouts[RLS_B_SHUT_LSB +: 4];

   // bus decode
   wire bus_req = cyc_i & stb_i & ~ack_o;
   wire [9:0] idx = adr_i[RLS_ADR_W-1:2];
   wire hit_a = idx == {2'h0, RLS_IDX_A_LOW_POWER};
   wire hit_bc = idx == {2'h0, RLS_IDX_B_CONTROL};
   wire hit_bt = idx == {2'h0, RLS_IDX_B_TIMEOUTS};
   wire hit_st = idx == {2'h0, RLS_IDX_IRQ_STATUS};
   wire hit_mk = idx == {2'h0, RLS_IDX_IRQ_MASK};
   wire hit_hb = idx == {2'h0, RLS_IDX_HIB_CTRL};
   wire hit_sr = idx == {2'h0, RLS_IDX_STATE};
   // writes land at the edge where the master samples ack
   wire wr = cyc_i & stb_i & we_i & ack_o;
   wire [15:0] lane_en = {{8{sel_i[1]}}, {8{sel_i[0]}}};
   wire [15:0] wdat = dat_i[15:0];

   // merge of a write into a 16-bit register through its writable bits
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wmask,
                                         input logic [15:0] data, input logic [15:0] lanes);
      logic [15:0] take;
      take = wmask & lanes;
      merge = (old & ~take) | (data & take);
   endfunction

   wire [15:0] next_a_low_power = merge(ldo_a_low_power, RLS_A_LOW_POWER_WMASK, wdat, lane_en);
   wire [15:0] next_b_control = merge(ldo_b_control, RLS_B_CONTROL_WMASK, wdat, lane_en);
   wire [15:0] next_b_timeouts = merge(ldo_b_timeouts, RLS_B_TIMEOUTS_WMASK, wdat, lane_en);

   // read mux; unmapped indices read zero
   wire [15:0] rd_state = {10'h000, all_discharge_o, reg_b_discharge_o, reg_b_switch_o,
                           reg_b_en_o, reg_a_in_sleep_o, reg_a_en_o};
   wire [15:0] rd_mux = hit_a ? ldo_a_low_power :
                        hit_bc ? ldo_b_control :
                        hit_bt ? ldo_b_timeouts :
                        hit_st ? {14'h0000, irq_status} :
                        hit_mk ? {14'h0000, irq_mask} :
                        hit_hb ? {15'h0000, hib_bit} :
                        hit_sr ? rd_state : 16'h0000;

   // configuration fields: bus writes and state machine reload
   always_ff @(posedge clk_i) begin
      if (rst_i || sm_reload_i) begin
         ldo_a_low_power <= mask_a_low_power_i & RLS_A_LOW_POWER_WMASK;
         ldo_b_control <= mask_b_control_i & RLS_B_CONTROL_WMASK;
         ldo_b_timeouts <= mask_b_timeouts_i & RLS_B_TIMEOUTS_WMASK;
      end else if (wr) begin
         if (hit_a) ldo_a_low_power <= next_a_low_power;
         if (hit_bc) ldo_b_control <= next_b_control;
         if (hit_bt) ldo_b_timeouts <= next_b_timeouts;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask <= '0;
         hib_bit <= 1'b0;
      end else if (wr && sel_i[0]) begin
         if (hit_mk) irq_mask <= wdat[RLS_IRQ_W-1:0];
         if (hit_hb) hib_bit <= wdat[0];
      end
   end

   // bus answer: one cycle after the request is seen
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= bus_req;
         dat_o <= bus_req && !we_i ? {16'h0000, rd_mux} : 32'h0000_0000;
      end
   end

   // regulator a hibernate
   wire sleep_sel = reg_a_sleep_source == RLS_SRC_REG_BIT ? hib_bit :
                    reg_a_sleep_source == RLS_SRC_LINE_ONE ? low_power_line_one_i :
                    reg_a_sleep_source == RLS_SRC_LINE_TWO ? low_power_line_two_i :
                    low_power_line_three_i;
   wire sleep_image = sleep_sel && reg_a_sleep_behaviour == RLS_BEHAV_IMAGE;
   wire sleep_off = sleep_sel && reg_a_sleep_behaviour == RLS_BEHAV_OFF;
   wire [4:0] a_code = sleep_image ? reg_a_sleep_voltage : reg_a_normal_code_i;
   wire [11:0] a_mv;
   wire [11:0] b_mv;

   rls_volt_decode u_dec_a (
      .code_i(a_code),
      .mv_o(a_mv)
   );

   rls_volt_decode u_dec_b (
      .code_i(reg_b_voltage_select),
      .mv_o(b_mv)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reg_a_en_o <= 1'b0;
         reg_a_out_mv_o <= 12'h000;
         reg_a_in_sleep_o <= 1'b0;
      end else begin
         reg_a_en_o <= reg_a_normal_en_i & ~sleep_off;
         reg_a_out_mv_o <= a_mv;
         reg_a_in_sleep_o <= sleep_sel;
      end
   end

   // regulator b sequencing
   wire slot_mid_start = reg_b_startup_slot != RLS_SLOT_NEVER &&
                         reg_b_startup_slot != RLS_SLOT_AT_EDGE;
   wire slot_mid_shut = reg_b_shutdown_slot != RLS_SLOT_NEVER &&
                        reg_b_shutdown_slot != RLS_SLOT_AT_EDGE;
   wire start_now = (startup_tick_i && slot_mid_start && slot_num_i == reg_b_startup_slot) ||
                    (active_entry_i && reg_b_startup_slot == RLS_SLOT_AT_EDGE);
   wire shut_now = (shutdown_tick_i && slot_mid_shut && slot_num_i == reg_b_shutdown_slot) ||
                   (off_entry_i && !slot_mid_shut);
   wire fault_stop = reg_b_fault_i && reg_b_fault_action == RLS_ACT_REG_OFF;
   wire fault_system = reg_b_fault_i && reg_b_fault_action[1];

   // stopping wins over starting in the same cycle
   always_comb begin
      next_b_state = b_state;
      unique case (b_state)
         RLS_B_IS_OFF: begin
            if (start_now && !shut_now && !reg_b_fault_i) next_b_state = RLS_B_IS_ON;
         end
         RLS_B_IS_ON: begin
            if (shut_now || fault_stop || fault_system) next_b_state = RLS_B_IS_OFF;
         end
      endcase
   end

   wire b_on_next = next_b_state == RLS_B_IS_ON;
   wire all_off_next = !b_on_next && others_en_i == 3'h0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         b_state <= RLS_B_IS_OFF;
         reg_b_en_o <= 1'b0;
         reg_b_switch_o <= 1'b0;
         reg_b_out_mv_o <= 12'h000;
         reg_b_discharge_o <= 1'b0;
         all_discharge_o <= 1'b0;
         system_shutdown_o <= 1'b0;
      end else begin
         b_state <= next_b_state;
         reg_b_en_o <= b_on_next;
         reg_b_switch_o <= reg_b_switch_mode;
         reg_b_out_mv_o <= reg_b_switch_mode ? 12'h000 : b_mv;
         reg_b_discharge_o <= !b_on_next && (!reg_b_float_output || all_off_next);
         all_discharge_o <= all_off_next;
         system_shutdown_o <= fault_system;
      end
   end

   // sticky interrupt status; a new event wins over a clear
   wire [RLS_IRQ_W-1:0] irq_set;
   wire [RLS_IRQ_W-1:0] irq_clr = wr && hit_st && sel_i[0] ? wdat[RLS_IRQ_W-1:0] : '0;
   assign irq_set[RLS_IRQ_FAULT_BIT] = reg_b_fault_i;
   assign irq_set[RLS_IRQ_SLEEP_BIT] = sleep_sel && !reg_a_in_sleep_o;

   genvar gi;
   generate
      for (gi = 0; gi < RLS_IRQ_W; gi = gi + 1) begin : g_irq
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               irq_status[gi] <= 1'b0;
            end else begin
               irq_status[gi] <= irq_set[gi] | (irq_status[gi] & ~irq_clr[gi]);
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_status & irq_mask);
      end
   end

   // expected millivolts for a code, for checking the decoder path
   function automatic logic [11:0] exp_mv(input logic [4:0] c);
      exp_mv = c[4] ? 12'(1800 + 100 * c[3:0]) : 12'(900 + 50 * c[3:0]);
   endfunction

   sequence s_fault_seen;
      reg_b_fault_i && irq_mask[RLS_IRQ_FAULT_BIT] && !rst_i;
   endsequence

   sequence s_flag_then_irq;
      irq_status[RLS_IRQ_FAULT_BIT] ##1 irq_o;
   endsequence

   property p_sleep_off;
      @(posedge clk_i) disable iff (rst_i)
      sleep_sel && reg_a_sleep_behaviour == 2'h1 |=> !reg_a_en_o;
   endproperty
   a_sleep_off: assert property (p_sleep_off) else $error("regulator a not off in sleep");

   property p_source_two;
      @(posedge clk_i) disable iff (rst_i)
      reg_a_sleep_source == 2'h2 && low_power_line_two_i |=> reg_a_in_sleep_o;
   endproperty
   a_source_two: assert property (p_source_two) else $error("line two did not trigger");

   property p_image_mv;
      @(posedge clk_i) disable iff (rst_i)
      sleep_sel && reg_a_sleep_behaviour == 2'h0 |=>
         reg_a_out_mv_o == exp_mv($past(reg_a_sleep_voltage));
   endproperty
   a_image_mv: assert property (p_image_mv) else $error("image voltage wrong");

   property p_switch;
      @(posedge clk_i) disable iff (rst_i)
      reg_b_switch_mode |=> reg_b_switch_o && reg_b_out_mv_o == 12'h000;
   endproperty
   a_switch: assert property (p_switch) else $error("switch mode still regulates");

   property p_float;
      @(posedge clk_i) disable iff (rst_i)
      !reg_b_en_o && !all_discharge_o && $past(reg_b_float_output)
         |-> !reg_b_discharge_o;
   endproperty
   a_float: assert property (p_float) else $error("floating output discharged");

   property p_all_off;
      @(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) && $past(others_en_i) == 3'h0 && !reg_b_en_o
         |-> all_discharge_o && reg_b_discharge_o;
   endproperty
   a_all_off: assert property (p_all_off) else $error("all-off discharge missing");

   property p_vsel;
      @(posedge clk_i) disable iff (rst_i)
      !reg_b_switch_mode |=> reg_b_out_mv_o == exp_mv($past(reg_b_voltage_select));
   endproperty
   a_vsel: assert property (p_vsel) else $error("voltage select wrong");

   property p_fault_irq;
      @(posedge clk_i) disable iff (rst_i)
      s_fault_seen |=> s_flag_then_irq;
   endproperty
   a_fault_irq: assert property (p_fault_irq) else $error("fault raised no interrupt");

   property p_fault_stop;
      @(posedge clk_i) disable iff (rst_i)
      reg_b_fault_i && reg_b_fault_action != 2'h0 |=> !reg_b_en_o;
   endproperty
   a_fault_stop: assert property (p_fault_stop) else $error("fault did not stop");

   property p_start;
      @(posedge clk_i) disable iff (rst_i)
      active_entry_i && reg_b_startup_slot == 4'hF && !shut_now && !reg_b_fault_i
         |=> reg_b_en_o;
   endproperty
   a_start: assert property (p_start) else $error("no start on active entry");

   property p_shut;
      @(posedge clk_i) disable iff (rst_i)
      off_entry_i && reg_b_shutdown_slot == 4'h0 |=> !reg_b_en_o;
   endproperty
   a_shut: assert property (p_shut) else $error("no stop on off entry");

   property p_reload;
      @(posedge clk_i) disable iff (rst_i)
      sm_reload_i |=> ldo_b_timeouts == ($past(mask_b_timeouts_i) & 16'hFFC0);
   endproperty
   a_reload: assert property (p_reload) else $error("reload missed mask default");

   property p_wake;
      @(posedge clk_i) disable iff (rst_i)
      !sleep_sel |=> !reg_a_in_sleep_o && reg_a_en_o == $past(reg_a_normal_en_i);
   endproperty
   a_wake: assert property (p_wake) else $error("regulator a stayed asleep");

endmodule
`default_nettype wire

/* File: rtl/rls_pkg.sv */
// constants for the regulator low-power and sequencing register bank
// assumes a 50 MHz clock and a classic wishbone slave with 32-bit data
package rls_pkg;

   // register indices; the byte address is four times the index
   localparam logic [7:0] RLS_IDX_A_LOW_POWER = 8'hD0;
   localparam logic [7:0] RLS_IDX_B_CONTROL = 8'hD1;
   localparam logic [7:0] RLS_IDX_B_TIMEOUTS = 8'hD2;
   localparam logic [7:0] RLS_IDX_IRQ_STATUS = 8'hE0;
   localparam logic [7:0] RLS_IDX_IRQ_MASK = 8'hE1;
   localparam logic [7:0] RLS_IDX_HIB_CTRL = 8'hE2;
   localparam logic [7:0] RLS_IDX_STATE = 8'hE3;
   localparam int RLS_ADR_W = 12;

   // field positions
   localparam int RLS_A_BEHAV_LSB = 12;
   localparam int RLS_A_SOURCE_LSB = 8;
   localparam int RLS_A_VOLT_LSB = 0;
   localparam int RLS_B_SWITCH_BIT = 14;
   localparam int RLS_B_FLOAT_BIT = 10;
   localparam int RLS_B_VSEL_LSB = 0;
   localparam int RLS_B_ACTION_LSB = 14;
   localparam int RLS_B_START_LSB = 10;
   localparam int RLS_B_SHUT_LSB = 6;
   localparam int RLS_IRQ_FAULT_BIT = 0;
   localparam int RLS_IRQ_SLEEP_BIT = 1;
   localparam int RLS_IRQ_W = 2;

   // writable bits of each register
   localparam logic [15:0] RLS_A_LOW_POWER_WMASK = 16'h331F;
   localparam logic [15:0] RLS_B_CONTROL_WMASK = 16'h441F;
   localparam logic [15:0] RLS_B_TIMEOUTS_WMASK = 16'hFFC0;

   // encodings
   localparam logic [1:0] RLS_BEHAV_IMAGE = 2'h0;
   localparam logic [1:0] RLS_BEHAV_OFF = 2'h1;
   localparam logic [1:0] RLS_SRC_REG_BIT = 2'h0;
   localparam logic [1:0] RLS_SRC_LINE_ONE = 2'h1;
   localparam logic [1:0] RLS_SRC_LINE_TWO = 2'h2;
   localparam logic [1:0] RLS_SRC_LINE_THREE = 2'h3;
   localparam logic [1:0] RLS_ACT_IGNORE = 2'h0;
   localparam logic [1:0] RLS_ACT_REG_OFF = 2'h1;
   localparam logic [3:0] RLS_SLOT_NEVER = 4'h0;
   localparam logic [3:0] RLS_SLOT_AT_EDGE = 4'hF;

   // voltage code steps in millivolts
   localparam logic [11:0] RLS_LOW_BASE_MV = 12'h384;
   localparam logic [11:0] RLS_LOW_STEP_MV = 12'h032;
   localparam logic [11:0] RLS_HIGH_BASE_MV = 12'h708;
   localparam logic [11:0] RLS_HIGH_STEP_MV = 12'h064;

   typedef enum logic {RLS_B_IS_OFF, RLS_B_IS_ON} rls_b_state_e;

endpackage

/* File: rtl/rls_volt_decode.sv */
// five-bit regulator voltage code to millivolts
// assumes nothing; pure combinational
`timescale 1ns/100ps
`default_nettype none
module rls_volt_decode
   import rls_pkg::*;
(
   // code in, millivolts out
   input wire logic [4:0] code_i,
   output logic [11:0] mv_o
);
   wire [11:0] step_count = {8'h00, code_i[3:0]};
   wire [23:0] low_prod = step_count * RLS_LOW_STEP_MV;
   wire [23:0] high_prod = step_count * RLS_HIGH_STEP_MV;
   // upper half of the code uses the coarse step from 1.8 V
   assign mv_o = code_i[4] ? RLS_HIGH_BASE_MV + high_prod[11:0]
                           : RLS_LOW_BASE_MV + low_prod[11:0];
endmodule
`default_nettype wire

/* File: tb/rls_seq_model.sv */
// partner model: power sequencer issuing slot ticks and state entries
// assumes one command per cycle from the bench and a 50 MHz clock
`timescale 1ns/100ps
`default_nettype none
module rls_seq_model (
   // clock and command
   input wire logic clk_i,
   input wire logic [2:0] cmd_i,
   input wire logic [3:0] slot_i,
   // sequencer events
   output logic startup_tick_o,
   output logic shutdown_tick_o,
   output logic active_entry_o,
   output logic off_entry_o,
   output logic [3:0] slot_num_o
);
   // slot number is only meaningful during a tick; otherwise it keeps changing
   always_ff @(posedge clk_i) begin
      startup_tick_o <= (cmd_i == 3'h1);
      shutdown_tick_o <= (cmd_i == 3'h2);
      active_entry_o <= (cmd_i == 3'h3);
      off_entry_o <= (cmd_i == 3'h4);
      slot_num_o <= (cmd_i == 3'h1 || cmd_i == 3'h2) ? slot_i : ~slot_num_o;
   end
endmodule
`default_nettype wire

/* File: tb/tb_regulator_lowpower_sequencing_regs.sv */
// self-checking bench for the regulator low-power and sequencing registers
// assumes rls_pkg, rls_regs and the sequencer model are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_regulator_lowpower_sequencing_regs;
   import rls_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, sm = 1'b0;
   logic [11:0] adr = 12'h000;
   logic [31:0] wdat = 32'h0, dat_o, q;
   logic ack_o, fault = 1'b0, n_en = 1'b0;
   logic [2:0] lines = 3'h0, others = 3'h0, cmd = 3'h0;
   logic [3:0] slot = 4'h0, slot_num;
   logic [4:0] n_code = 5'h00;
   logic [4:0] codes [5] = '{5'h00, 5'h0F, 5'h10, 5'h1F, 5'h0A};
   logic [15:0] mk_a = 16'hA55A, mk_b = 16'h5AA5, mk_t = 16'hC3C3;
   logic st_tk, sd_tk, act_e, off_e;
   logic a_en, a_sl, b_en, b_sw, b_dis, all_dis, sys_sd, irq;
   logic [11:0] a_mv, b_mv;
   int num_errors = 0, cmp_count = 0, cycles = 0;
   rls_regs u_rls_regs (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
      .sm_reload_i(sm), .mask_a_low_power_i(mk_a), .mask_b_control_i(mk_b),
      .mask_b_timeouts_i(mk_t), .low_power_line_one_i(lines[0]),
      .low_power_line_two_i(lines[1]), .low_power_line_three_i(lines[2]),
      .reg_a_normal_en_i(n_en), .reg_a_normal_code_i(n_code), .startup_tick_i(st_tk),
      .shutdown_tick_i(sd_tk), .slot_num_i(slot_num), .active_entry_i(act_e),
      .off_entry_i(off_e), .reg_b_fault_i(fault), .others_en_i(others), .reg_a_en_o(a_en),
      .reg_a_out_mv_o(a_mv), .reg_a_in_sleep_o(a_sl), .reg_b_en_o(b_en), .reg_b_switch_o(b_sw),
      .reg_b_out_mv_o(b_mv), .reg_b_discharge_o(b_dis), .all_discharge_o(all_dis),
      .system_shutdown_o(sys_sd), .irq_o(irq));
   rls_seq_model u_rls_seq_model (.clk_i(clk_i), .cmd_i(cmd), .slot_i(slot),
      .startup_tick_o(st_tk), .shutdown_tick_o(sd_tk), .active_entry_o(act_e),
      .off_entry_o(off_e), .slot_num_o(slot_num));
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors = num_errors + 1;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("errors %0d, comparisons %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_sig(input string nm, input logic [11:0] e, input logic [11:0] g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] idx, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {2'h0, idx, 2'h0};
      wdat <= {16'h0000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      if (n >= 50) begin
         num_errors++;
         $display("[FAIL] ack expected 1 seen %b", ack_o);
      end
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] idx, input logic [31:0] e);
      wb(1'b0, idx, 16'h0000);
      chk_reg("read data", e, q);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic seq(input logic [2:0] c, input logic [3:0] s);
      @(posedge clk_i);
      cmd <= c;
      slot <= s;
      @(posedge clk_i);
      cmd <= 3'h0;
      tick(3);
   endtask
   function automatic logic [11:0] mv(input logic [4:0] c);
      return c[4] ? 12'd1800 + 12'd100 * {8'h00, c[3:0]} : 12'd900 + 12'd50 * {7'h00, c};
   endfunction
   initial begin
      logic [1:0] act;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      // registers after reset, access kinds, unmapped place, reload
      rd(8'hD0, 32'h211A);
      rd(8'hD1, 32'h4005);
      rd(8'hD2, 32'hC3C0);
      wb(1'b1, 8'h10, 16'hFFFF);
      rd(8'h10, 32'h0000);
      wb(1'b1, 8'hD0, 16'h0000);
      wb(1'b1, 8'hD2, 16'h0000);
      rd(8'hD0, 32'h0000);
      @(posedge clk_i);
      sm <= 1'b1;
      @(posedge clk_i);
      sm <= 1'b0;
      rd(8'hD0, 32'h211A);
      rd(8'hD2, 32'hC3C0);
      wb(1'b1, 8'hD2, 16'h0000);
      $display("test reset and access done");
      // voltage select and switch mode
      foreach (codes[i]) begin
         wb(1'b1, 8'hD1, {11'h000, codes[i]});
         tick(2);
         chk_sig("b voltage", mv(codes[i]), b_mv);
      end
      wb(1'b1, 8'hD1, 16'h401F);
      tick(2);
      chk_sig("b switch", 12'h001, {11'h000, b_sw});
      chk_sig("b voltage", 12'h000, b_mv);
      $display("test voltage done");
      // discharge with float bit and with all regulators off
      wb(1'b1, 8'hD1, 16'h0400);
      others <= 3'h7;
      tick(2);
      chk_sig("b discharge", 12'h000, {11'h000, b_dis});
      @(posedge clk_i) others <= 3'h0;
      tick(2);
      chk_sig("all discharge", 12'h001, {11'h000, all_dis});
      chk_sig("b discharge", 12'h001, {11'h000, b_dis});
      wb(1'b1, 8'hD1, 16'h0000);
      others <= 3'h7;
      tick(2);
      chk_sig("b discharge", 12'h001, {11'h000, b_dis});
      $display("test discharge done");
      // start-up and shutdown slots
      wb(1'b1, 8'hD2, 16'h0D40);
      seq(3'h1, 4'h2);
      chk_sig("b enable", 12'h000, {11'h000, b_en});
      seq(3'h1, 4'h3);
      chk_sig("b enable", 12'h001, {11'h000, b_en});
      seq(3'h2, 4'h4);
      chk_sig("b enable", 12'h001, {11'h000, b_en});
      seq(3'h2, 4'h5);
      chk_sig("b enable", 12'h000, {11'h000, b_en});
      for (int s = 0; s < 2; s++) begin
         wb(1'b1, 8'hD2, s ? 16'h3FC0 : 16'h3C00);
         seq(3'h3, 4'h0);
         chk_sig("b enable", 12'h001, {11'h000, b_en});
         seq(3'h4, 4'h0);
         chk_sig("b enable", 12'h000, {11'h000, b_en});
      end
      $display("test slots done");
      // fault actions, interrupt mask and clear
      wb(1'b1, 8'hE1, 16'h0001);
      for (int a = 0; a < 5; a++) begin
         act = a[1:0];
         if (a == 4) wb(1'b1, 8'hE1, 16'h0000);
         wb(1'b1, 8'hD2, {act, 14'h3C00});
         seq(3'h3, 4'h0);
         @(posedge clk_i);
         fault <= 1'b1;
         @(posedge clk_i);
         fault <= 1'b0;
         #1;
         chk_sig("sys shutdown", {11'h000, act[1]}, {11'h000, sys_sd});
         chk_sig("b enable", {11'h000, act == 2'h0}, {11'h000, b_en});
         tick(1);
         chk_sig("irq", {11'h000, a != 4}, {11'h000, irq});
         rd(8'hE0, 32'h0001);
         wb(1'b1, 8'hE0, 16'h0001);
         tick(2);
         chk_sig("irq", 12'h000, {11'h000, irq});
      end
      $display("test fault done");
      // hibernate sources, image voltage and return to normal
      @(posedge clk_i);
      n_en <= 1'b1;
      n_code <= 5'h04;
      for (int s = 1; s < 4; s++) begin
         wb(1'b1, 8'hD0, {6'h00, s[1:0], 8'h1C});
         lines <= 3'h1 << (s - 1);
         tick(3);
         chk_sig("a sleep", 12'h001, {11'h000, a_sl});
         chk_sig("a voltage", mv(5'h1C), a_mv);
         @(posedge clk_i) lines <= 3'h0;
         tick(3);
         chk_sig("a voltage", mv(5'h04), a_mv);
         chk_sig("a sleep", 12'h000, {11'h000, a_sl});
      end
      wb(1'b1, 8'hD0, 16'h1000);
      wb(1'b1, 8'hE2, 16'h0001);
      tick(3);
      chk_sig("a enable", 12'h000, {11'h000, a_en});
      wb(1'b1, 8'hE2, 16'h0000);
      tick(3);
      chk_sig("a enable", 12'h001, {11'h000, a_en});
      rd(8'hE0, 32'h0002);
      $display("test hibernate done");
      end_of_test();
   end
endmodule
`default_nettype wire
